// *** design/sxa_pkg.sv ***
// Purpose: Constants and types for the subtract, exclusive-OR and nibble-exchange datapath
// Assumes: One core clock; decoder issues one operation per valid pulse
// Notes: All values are named here once
// How it works
// - Subtraction is register minus accumulator; borrow flags are set when no borrow occurs.
// - target_select 0 sends a register-operand result to the accumulator, 1 to the register.
// - Register exclusive-OR combines accumulator and register and touches only the zero flag.
// - Nibble exchange swaps the two halves of the register and leaves all flags alone.
// - Literal exclusive-OR mixes the accumulator with an 8-bit literal into the accumulator.
package sxa_pkg;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 7;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic TARGET_ACC = 1'b0;
    localparam logic TARGET_REG = 1'b1;

    typedef enum logic [1:0] {
        SXA_OP_MINUS = 2'b00,
        SXA_OP_XOR_REG = 2'b01,
        SXA_OP_SWAP = 2'b11,
        SXA_OP_XOR_LIT = 2'b10
    } sxa_op_e;

    typedef logic [7:0] sxa_byte_t;
endpackage

// *** design/sxa_op_if.sv ***
// Purpose: Carries operands and results between the top and its compute unit
// Assumes: Purely combinational traffic
// Notes: None
`timescale 1ns/1ps
interface sxa_op_if;
    sxa_pkg::sxa_op_e op;
    sxa_pkg::sxa_byte_t reg_val;
    sxa_pkg::sxa_byte_t acc_val;
    sxa_pkg::sxa_byte_t lit_val;
    sxa_pkg::sxa_byte_t result;
    logic borrow;
    logic nib_borrow;
    logic upd_borrow;
    logic upd_zero;
    modport top (output op, output reg_val, output acc_val, output lit_val,
        input result, input borrow, input nib_borrow, input upd_borrow, input upd_zero);
    modport unit (input op, input reg_val, input acc_val, input lit_val,
        output result, output borrow, output nib_borrow, output upd_borrow, output upd_zero);
endinterface

// *** design/sxa_compute.sv ***
// Purpose: Combinational result and flag computation for the four operations
// Assumes: Operands stable when sampled by the top
// Notes: Borrow flags are active-high "no borrow" as on this core
`timescale 1ns/1ps
module sxa_compute (
    sxa_op_if.unit bus
);
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb begin
        diff = {1'b0, bus.reg_val} - {1'b0, bus.acc_val};
        ndiff = {1'b0, bus.reg_val[3:0]} - {1'b0, bus.acc_val[3:0]};
        bus.result = 8'h00;
        bus.upd_borrow = 1'b0;
        bus.upd_zero = 1'b0;
        unique case (bus.op)
            sxa_pkg::SXA_OP_MINUS: begin
                bus.result = diff[7:0];
                bus.upd_borrow = 1'b1;
                bus.upd_zero = 1'b1;
            end
            sxa_pkg::SXA_OP_XOR_REG: begin
                bus.result = bus.acc_val ^ bus.reg_val;
                bus.upd_zero = 1'b1;
            end
            sxa_pkg::SXA_OP_SWAP: begin
                bus.result = {bus.reg_val[3:0], bus.reg_val[7:4]};
            end
            sxa_pkg::SXA_OP_XOR_LIT: begin
                bus.result = bus.acc_val ^ bus.lit_val;
                bus.upd_zero = 1'b1;
            end
        endcase
        // Top bit of the widened difference is the borrow; flag means no borrow
        bus.borrow = ~diff[8];
        bus.nib_borrow = ~ndiff[4];
    end
endmodule

// *** design/sxa_alu.sv ***
// Purpose: Top of the datapath; holds accumulator and flags, issues register write-back
// Assumes: op_valid is a one-cycle pulse from the decoder with operands valid alongside
// Notes: Write-back to the register file is a registered one-cycle strobe
`timescale 1ns/1ps
module sxa_alu (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic target_select,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_data,
    input wire logic [7:0] literal,
    output logic [7:0] accum,
    output logic borrow_out_flag,
    output logic nibble_borrow_flag,
    output logic result_null_flag,
    output logic reg_wr_en,
    output logic [6:0] reg_wr_addr,
    output logic [7:0] reg_wr_data
);
    sxa_op_if opi ();

    sxa_compute u_compute (
        .bus(opi)
    );

    logic [7:0] acc_q, acc_d;
    logic c_q, c_d, nb_q, nb_d, z_q, z_d;
    logic we_q, we_d;
    logic [6:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;
    logic to_reg;

    ////////////////////////////////////////////////////////////////////////
    assign opi.op = sxa_pkg::sxa_op_e'(op_code);
    assign opi.reg_val = reg_data;
    assign opi.acc_val = acc_q;
    assign opi.lit_val = literal;

    always_comb begin
        acc_d = acc_q;
        c_d = c_q;
        nb_d = nb_q;
        z_d = z_q;
        we_d = 1'b0;
        wa_d = wa_q;
        wd_d = wd_q;
        // Literal form has no register operand, so it ignores target_select
        to_reg = (target_select == sxa_pkg::TARGET_REG) &&
                 (opi.op != sxa_pkg::SXA_OP_XOR_LIT);
        if (op_valid) begin
            if (to_reg) begin
                we_d = 1'b1;
                wa_d = reg_addr;
                wd_d = opi.result;
            end else begin
                acc_d = opi.result;
            end
            if (opi.upd_borrow) begin
                c_d = opi.borrow;
                nb_d = opi.nib_borrow;
            end
            if (opi.upd_zero) begin
                z_d = (opi.result == 8'h00);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= sxa_pkg::ACC_RST;
            c_q <= sxa_pkg::FLAG_RST;
            nb_q <= sxa_pkg::FLAG_RST;
            z_q <= sxa_pkg::FLAG_RST;
            we_q <= 1'b0;
            wa_q <= 7'h00;
            wd_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
            c_q <= c_d;
            nb_q <= nb_d;
            z_q <= z_d;
            we_q <= we_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign accum = acc_q;
    assign borrow_out_flag = c_q;
    assign nibble_borrow_flag = nb_q;
    assign result_null_flag = z_q;
    assign reg_wr_en = we_q;
    assign reg_wr_addr = wa_q;
    assign reg_wr_data = wd_q;
endmodule

// *** testbench/sxa_alu_properties.sv ***
// Purpose: Port-level properties of the datapath
// Assumes: Results show one cycle after op_valid
// Notes: Bound to the top at the foot
`timescale 1ns/1ps
module sxa_alu_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic target_select,
    input wire logic [7:0] reg_data,
    input wire logic [7:0] literal,
    input wire logic [7:0] accum,
    input wire logic borrow_out_flag,
    input wire logic nibble_borrow_flag,
    input wire logic result_null_flag,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_sub;
        op_valid && op_code == 2'h0 |=> borrow_out_flag == ($past(accum) <= $past(reg_data))
            && nibble_borrow_flag == ($past(accum[3:0]) <= $past(reg_data[3:0]));
    endproperty
    a_sub: assert property (p_sub) else $error("borrow flags wrong");
    property p_dst;
        op_valid && op_code != 2'h2 |=> reg_wr_en == $past(target_select);
    endproperty
    a_dst: assert property (p_dst) else $error("destination wrong");
    property p_xor;
        op_valid && op_code == 2'h1 |=> $stable({borrow_out_flag, nibble_borrow_flag})
            && (reg_wr_en ? reg_wr_data : accum) == ($past(accum) ^ $past(reg_data));
    endproperty
    a_xor: assert property (p_xor) else $error("register xor wrong");
    property p_swap;
        op_valid && op_code == 2'h3 |=> $stable({borrow_out_flag, nibble_borrow_flag,
            result_null_flag}) && (reg_wr_en ? reg_wr_data : accum) ==
            {$past(reg_data[3:0]), $past(reg_data[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");
    property p_lit;
        op_valid && op_code == 2'h2 |=> !reg_wr_en && accum == ($past(accum) ^ $past(literal));
    endproperty
    a_lit: assert property (p_lit) else $error("literal xor wrong");
    property p_zero;
        op_valid && !target_select && op_code != 2'h3 |=> result_null_flag == (accum == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule

bind sxa_alu sxa_alu_checker chk (.clk(clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .target_select(target_select), .reg_data(reg_data), .literal(literal),
    .accum(accum), .borrow_out_flag(borrow_out_flag), .nibble_borrow_flag(nibble_borrow_flag),
    .result_null_flag(result_null_flag), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));

// *** testbench/sxa_alu_tb.sv ***
// Purpose: Directed checks of the four datapath operations
// Assumes: Inputs move on the falling edge
// Notes: Expected values come from a small model kept here
`timescale 1ns/1ps
module sxa_alu_tb;
    logic clk = 0, arst_n = 0, op_valid = 0, ts = 0, c, nb, z, we, cx = 0, dx = 0, zx = 0;
    logic [6:0] ra = 7'h00, wa;
    logic [1:0] op = 2'h0;
    logic [7:0] rd = 8'h00, lit = 8'h00, acc, wd, ax = 8'h00;
    int error_cnt = 0, checked = 0;
    always #25 clk = ~clk;
    sxa_alu uut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op),
        .target_select(ts), .reg_addr(ra), .reg_data(rd), .literal(lit), .accum(acc),
        .borrow_out_flag(c), .nibble_borrow_flag(nb), .result_null_flag(z), .reg_wr_en(we),
        .reg_wr_addr(wa), .reg_wr_data(wd));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input logic [1:0] o, input logic t, input logic [7:0] r,
        input logic [7:0] k);
        logic [7:0] y;
        logic wb;
        y = o == 2'h0 ? r - ax : o == 2'h3 ? {r[3:0], r[7:4]} : ax ^ (o == 2'h2 ? k : r);
        if (o == 2'h0) begin
            cx = ax <= r;
            dx = ax[3:0] <= r[3:0];
        end
        if (o != 2'h3) zx = y == 8'h00;
        wb = t && o != 2'h2;
        if (!wb) ax = y;
        @(negedge clk);
        {op_valid, op, ts, rd, lit, ra} = {1'b1, o, t, r, k, r[6:0] ^ 7'h2a};
        @(negedge clk);
        op_valid = 1'b0;
        check(acc, ax);
        check({5'h00, c, nb, z}, {5'h00, cx, dx, zx});
        check({7'h00, we}, {7'h00, wb});
        if (wb) check(wd, y);
        if (wb) check({1'b0, wa}, {1'b0, r[6:0] ^ 7'h2a});
    endtask
    initial begin
        repeat (2) @(negedge clk);
        check(acc, 8'h00);
        arst_n = 1'b1;
        run(2'h2, 1'b0, 8'h00, 8'h3c);
        run(2'h2, 1'b1, 8'h00, 8'h3c);
        run(2'h2, 1'b0, 8'h00, 8'h03);
        run(2'h0, 1'b1, 8'h05, 8'h00);
        run(2'h0, 1'b0, 8'h02, 8'h00);
        run(2'h0, 1'b0, 8'hff, 8'h00);
        run(2'h2, 1'b0, 8'h00, 8'h0f);
        run(2'h0, 1'b0, 8'h20, 8'h00);
        run(2'h1, 1'b1, 8'h11, 8'h00);
        run(2'h1, 1'b0, 8'h5a, 8'h00);
        run(2'h3, 1'b0, 8'ha5, 8'h00);
        run(2'h3, 1'b1, 8'h0f, 8'h00);
        complete_run;
    end
    initial begin
        repeat (400) @(posedge clk);
        error_cnt++;
        complete_run;
    end
endmodule
